// *** pslc_host_model.sv ***
// host master model: byte-level strobes toward the slave front end
// assumes the bench calls one task at a time, just after a clock edge
`timescale 1ns/1ps
module pslc_host_model (
  input wire clk_in,
  input wire [7:0] rd_data_in,
  output reg [7:0] addr_out,
  output reg [7:0] wdata_out,
  output reg wr_out,
  output reg rd_out,
  output reg start_out,
  output reg stop_out
);
  initial {addr_out, wdata_out, wr_out, rd_out, start_out, stop_out} = 20'h00000;
  // one strobe edge then a quiet edge; released data shows its inverse
  task cyc(input [7:0] a, input [7:0] d, input w);
    addr_out <= a;
    wdata_out <= d;
    wr_out <= w;
    rd_out <= !w;
    @(posedge clk_in);
    wr_out <= 1'b0;
    rd_out <= 1'b0;
    wdata_out <= ~d;
    @(posedge clk_in);
  endtask
  // read data is held until the next read, so take it after the quiet edge
  task rd(input [7:0] a, output [7:0] q);
    cyc(a, 8'h00, 1'b0);
    q = rd_data_in;
  endtask
  // high byte first, both inside one write transaction
  task word(input [15:0] w);
    cyc(8'h7e, w[15:8], 1'b1);
    cyc(8'h7e, w[7:0], 1'b1);
  endtask
  // s=0 start pulse, s=1 stop pulse
  task ev(input s);
    start_out <= !s;
    stop_out <= s;
    @(posedge clk_in);
    {start_out, stop_out} <= 2'b00;
    @(posedge clk_in);
  endtask
endmodule // pslc_host_model

// *** pslc_irq_bits.v ***
// one timer's cycle-done and script-done sticky pending bits with masking
// assumes event and clear strobes are one-cycle pulses on CLOCK_IN
`timescale 1ns/1ps
module pslc_irq_bits (
  input wire clk_in,
  input wire rst_in,
  input wire cycle_event_in,
  input wire script_event_in,
  input wire cycle_clear_in,
  input wire script_clear_in,
  input wire cycle_mask_in,
  input wire script_mask_in,
  output wire [1:0] raw_out,
  output wire [1:0] masked_out
);
  reg cycle_q;
  reg script_q;

  // set wins over a clear landing in the same cycle, so no event is lost
  always @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      cycle_q <= 1'b0;
      script_q <= 1'b0;
    end else begin
      cycle_q <= cycle_event_in | (cycle_q & ~cycle_clear_in);
      script_q <= script_event_in | (script_q & ~script_clear_in);
    end
  end

  // clearing the raw bit clears the masked view too
  assign raw_out = {script_q, cycle_q};
  assign masked_out = {script_q & script_mask_in, cycle_q & cycle_mask_in};
endmodule // pslc_irq_bits

// *** pslc_map.vh ***
// register offsets, field positions and reset values of the pwm script load slice
// included by the register slice, checker and bench, not by the store or irq bits; definitions only
`ifndef PSLC_MAP_VH
`define PSLC_MAP_VH
`define PSLC_ADDR_IRQ_CLEAR 8'h7c
`define PSLC_ADDR_WR_PTR 8'h7d
`define PSLC_ADDR_WORD_PORT 8'h7e
`define PSLC_ADDR_SLAVE_MAKER 8'h80
`define PSLC_CLR_SCRIPT_MSB 5
`define PSLC_CLR_SCRIPT_LSB 3
`define PSLC_CLR_CYCLE_MSB 2
`define PSLC_CLR_CYCLE_LSB 0
`define PSLC_PTR_RESET 7'h00
`define PSLC_PTR_INVALID 7'h60
`define PSLC_SLAVE_RESET 7'h44
// maker code value is arbitrary, chosen for this slice only
`define PSLC_MAKER_CODE 8'h5a
`endif

// *** pslc_regs.v ***
// host register slice of the pwm unit: irq clear, script pointer, script port,
// and the shared slave address / maker code location.
// assumes a byte-level slave front end delivering write strobes, read
// strobes, a transaction start and stop pulse, all synchronous to CLOCK_IN.
`timescale 1ns/1ps
`include "pslc_map.vh"
module pslc_regs #(
  parameter TIMERS = 3,
  parameter SLOTS = 96
) (
  input wire CLOCK_IN,
  input wire RST_IN,
  input wire [7:0] REG_ADDR_IN,
  input wire [7:0] WR_DATA_IN,
  input wire WR_STROBE_IN,
  input wire RD_STROBE_IN,
  input wire XFER_START_IN,
  input wire BUS_STOP_IN,
  output reg [7:0] RD_DATA_OUT,
  output wire NEXT_ADDR_INC_OUT,
  input wire [2:0] CYCLE_DONE_IN,
  input wire [2:0] SCRIPT_DONE_IN,
  input wire [2:0] CYCLE_MASK_IN,
  input wire [2:0] SCRIPT_MASK_IN,
  output wire [5:0] RAW_IRQ_STATUS_OUT,
  output wire [5:0] MASKED_IRQ_STATUS_OUT,
  input wire [6:0] SCRIPT_RD_ADDR_IN,
  output wire [15:0] SCRIPT_RD_DATA_OUT,
  output reg [6:0] SLAVE_ADDR_OUT
);
  // pointer field width, fixed by the seven-bit slot index
  localparam PTR_W = 7;

  // pointer and byte pairing state
  reg [6:0] ptr_q;
  reg [6:0] ptr_d;
  reg [7:0] high_byte_q;
  reg [7:0] high_byte_d;
  reg have_high_q;
  reg have_high_d;

  // slave address staging
  reg [6:0] slave_pend_q;
  reg [6:0] slave_pend_d;
  reg slave_pend_valid_q;
  reg slave_pend_valid_d;
  reg [6:0] slave_addr_d;

  // read path and store write side
  reg [7:0] rd_data_d;
  reg word_wr;
  reg [15:0] word_data;

  // decode and status wiring
  wire wr_clear;
  wire wr_ptr;
  wire wr_port;
  wire wr_slave;
  wire pair_reset;
  wire ptr_ok;
  wire [5:0] clr_bits;
  wire [2:0] cycle_clr;
  wire [2:0] script_clr;
  wire [1:0] raw_t [0:2];
  wire [1:0] msk_t [0:2];
  wire [2:0] raw_cycle;
  wire [2:0] raw_script;
  wire [2:0] msk_cycle;
  wire [2:0] msk_script;

  // one strobe at one register address; shared by every write decode
  function addr_hit;
    input strobe;
    input [7:0] addr;
    input [7:0] place;
    begin
      addr_hit = strobe && (addr == place);
    end
  endfunction

  // values from 96 up name no slot and must never reach the store
  function ptr_in_range;
    input [6:0] ptr;
    begin
      ptr_in_range = (ptr < `PSLC_PTR_INVALID);
    end
  endfunction

  // one step is one whole word; a step from 95 only lands in the invalid range
  function [6:0] ptr_step;
    input [6:0] ptr;
    begin
      ptr_step = ptr + 7'h01;
    end
  endfunction

  // address decode for host writes
  assign wr_clear = addr_hit(WR_STROBE_IN, REG_ADDR_IN, `PSLC_ADDR_IRQ_CLEAR);
  assign wr_ptr = addr_hit(WR_STROBE_IN, REG_ADDR_IN, `PSLC_ADDR_WR_PTR);
  assign wr_port = addr_hit(WR_STROBE_IN, REG_ADDR_IN, `PSLC_ADDR_WORD_PORT);
  assign wr_slave = addr_hit(WR_STROBE_IN, REG_ADDR_IN, `PSLC_ADDR_SLAVE_MAKER);

  // transaction edges end any half-built word
  assign pair_reset = XFER_START_IN || BUS_STOP_IN;
  assign ptr_ok = ptr_in_range(ptr_q);

  // clear strobes are not stored: write-only, self-clearing by design
  assign clr_bits = wr_clear ? WR_DATA_IN[5:0] : 6'h00;

  // reserved bits 7:6 never reach a pending bit
  assign cycle_clr = clr_bits[`PSLC_CLR_CYCLE_MSB:`PSLC_CLR_CYCLE_LSB];
  assign script_clr = clr_bits[`PSLC_CLR_SCRIPT_MSB:`PSLC_CLR_SCRIPT_LSB];

  // the front end holds the address on the script port instead of incrementing
  assign NEXT_ADDR_INC_OUT = (REG_ADDR_IN != `PSLC_ADDR_WORD_PORT);

  // per-timer pending bits, clear bit positions taken from the map
  genvar t;
  generate
    for (t = 0; t < TIMERS; t = t + 1) begin : g_timer
      pslc_irq_bits u_bits (
        .clk_in(CLOCK_IN),
        .rst_in(RST_IN),
        .cycle_event_in(CYCLE_DONE_IN[t]),
        .script_event_in(SCRIPT_DONE_IN[t]),
        .cycle_clear_in(cycle_clr[t]),
        .script_clear_in(script_clr[t]),
        .cycle_mask_in(CYCLE_MASK_IN[t]),
        .script_mask_in(SCRIPT_MASK_IN[t]),
        .raw_out(raw_t[t]),
        .masked_out(msk_t[t])
      );
    end
  endgenerate

  // split each timer pair into the cycle and script groups, timer 0 lowest
  generate
    for (t = 0; t < TIMERS; t = t + 1) begin : g_pack
      assign raw_cycle[t] = raw_t[t][0];
      assign raw_script[t] = raw_t[t][1];
      assign msk_cycle[t] = msk_t[t][0];
      assign msk_script[t] = msk_t[t][1];
    end
  endgenerate

  // status packing: script-done in 5:3, cycle-done in 2:0
  assign RAW_IRQ_STATUS_OUT = {raw_script, raw_cycle};
  assign MASKED_IRQ_STATUS_OUT = {msk_script, msk_cycle};

  // word assembly: first byte is high, second completes the word
  always @* begin
    word_wr = 1'b0;
    word_data = {high_byte_q, WR_DATA_IN};
    ptr_d = ptr_q;
    high_byte_d = high_byte_q;
    have_high_d = have_high_q;
    if (wr_ptr) begin
      ptr_d = WR_DATA_IN[6:0];
    end else if (wr_port && have_high_q) begin
      // invalid pointer drops the word and leaves the pointer alone
      if (ptr_ok) begin
        word_wr = 1'b1;
        ptr_d = ptr_step(ptr_q);
      end
    end
    // pairing flag flips per port byte; a bus edge drops a lone byte
    if (pair_reset) begin
      have_high_d = 1'b0;
    end else if (wr_port) begin
      have_high_d = ~have_high_q;
      if (!have_high_q) begin
        high_byte_d = WR_DATA_IN;
      end
    end
  end

  // pointer and byte pairing registers
  always @(posedge CLOCK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      ptr_q <= `PSLC_PTR_RESET;
      high_byte_q <= 8'h00;
      have_high_q <= 1'b0;
    end else begin
      ptr_q <= ptr_d;
      high_byte_q <= high_byte_d;
      have_high_q <= have_high_d;
    end
  end

  // storage is written only on the second byte of a pair
  pslc_script_store #(
    .SLOTS(SLOTS),
    .AW(PTR_W)
  ) u_store (
    .clk_in(CLOCK_IN),
    .wr_in(word_wr),
    .wr_addr_in(ptr_q),
    .wr_data_in(word_data),
    .rd_addr_in(SCRIPT_RD_ADDR_IN),
    .rd_data_out(SCRIPT_RD_DATA_OUT)
  );

  // slave address: staged on write, applied only at the next stop
  always @* begin
    slave_pend_d = slave_pend_q;
    slave_pend_valid_d = slave_pend_valid_q;
    slave_addr_d = SLAVE_ADDR_OUT;
    if (wr_slave) begin
      slave_pend_d = WR_DATA_IN[7:1];
      slave_pend_valid_d = 1'b1;
    end else if (BUS_STOP_IN && slave_pend_valid_q) begin
      slave_addr_d = slave_pend_q;
      slave_pend_valid_d = 1'b0;
    end
  end

  // applying mid-transaction would drop the host that is talking now
  always @(posedge CLOCK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      slave_pend_q <= `PSLC_SLAVE_RESET;
      slave_pend_valid_q <= 1'b0;
      SLAVE_ADDR_OUT <= `PSLC_SLAVE_RESET;
    end else begin
      slave_pend_q <= slave_pend_d;
      slave_pend_valid_q <= slave_pend_valid_d;
      SLAVE_ADDR_OUT <= slave_addr_d;
    end
  end

  // read data: write-only locations read zero, shared address returns maker code
  always @* begin
    rd_data_d = RD_DATA_OUT;
    if (RD_STROBE_IN) begin
      case (REG_ADDR_IN)
        `PSLC_ADDR_WR_PTR: rd_data_d = {1'b0, ptr_q};
        `PSLC_ADDR_SLAVE_MAKER: rd_data_d = `PSLC_MAKER_CODE;
        `PSLC_ADDR_IRQ_CLEAR: rd_data_d = 8'h00;
        `PSLC_ADDR_WORD_PORT: rd_data_d = 8'h00;
        default: rd_data_d = 8'h00;
      endcase
    end
  end

  // read byte held until the next read strobe
  always @(posedge CLOCK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      RD_DATA_OUT <= 8'h00;
    end else begin
      RD_DATA_OUT <= rd_data_d;
    end
  end
endmodule // pslc_regs

// *** pslc_regs_checker.sv ***
// port-level checks on the pwm script load slice
// assumes pslc_regs is compiled first; bound at the foot of this file
`timescale 1ns/1ps
`include "pslc_map.vh"
module pslc_regs_checker (
  input wire CLOCK_IN,
  input wire RST_IN,
  input wire [7:0] REG_ADDR_IN,
  input wire [7:0] WR_DATA_IN,
  input wire WR_STROBE_IN,
  input wire RD_STROBE_IN,
  input wire [7:0] RD_DATA_OUT,
  input wire NEXT_ADDR_INC_OUT,
  input wire [2:0] CYCLE_DONE_IN,
  input wire [2:0] SCRIPT_DONE_IN,
  input wire [2:0] CYCLE_MASK_IN,
  input wire [2:0] SCRIPT_MASK_IN,
  input wire [5:0] RAW_IRQ_STATUS_OUT,
  input wire [5:0] MASKED_IRQ_STATUS_OUT
);
  default clocking @(posedge CLOCK_IN); endclocking
  default disable iff (RST_IN);
  // a set in the same cycle beats the clear, so events are masked out
  wire clr = WR_STROBE_IN && REG_ADDR_IN == 8'h7c;
  wire [5:0] ev = {SCRIPT_DONE_IN, CYCLE_DONE_IN};
  wire [5:0] raw = RAW_IRQ_STATUS_OUT;
  property p_clr; clr |=> (raw & $past(WR_DATA_IN[5:0] & ~ev)) == 6'h00; endproperty
  a_clr: assert property (p_clr) else $error("pending bit survived its clear");
  property p_keep; clr |=> (raw | ~$past(raw & ~WR_DATA_IN[5:0])) == 6'h3f; endproperty
  a_keep: assert property (p_keep) else $error("zero bit cleared a pending bit");
  property p_cyc; |CYCLE_DONE_IN |=> (raw[2:0] & $past(CYCLE_DONE_IN)) == $past(CYCLE_DONE_IN);
  endproperty
  a_cyc: assert property (p_cyc) else $error("cycle event not latched");
  property p_scr; |SCRIPT_DONE_IN |=> (raw[5:3] & $past(SCRIPT_DONE_IN)) == $past(SCRIPT_DONE_IN);
  endproperty
  a_scr: assert property (p_scr) else $error("script event not latched");
  property p_mask; MASKED_IRQ_STATUS_OUT == (raw & {SCRIPT_MASK_IN, CYCLE_MASK_IN}); endproperty
  a_mask: assert property (p_mask) else $error("masked status wrong");
  property p_mkr; RD_STROBE_IN && REG_ADDR_IN == 8'h80 |=> RD_DATA_OUT == `PSLC_MAKER_CODE;
  endproperty
  a_mkr: assert property (p_mkr) else $error("maker code read wrong");
  property p_wo; RD_STROBE_IN && REG_ADDR_IN inside {8'h7c, 8'h7e} |=> RD_DATA_OUT == 8'h00;
  endproperty
  a_wo: assert property (p_wo) else $error("write-only place read nonzero");
  property p_inc; NEXT_ADDR_INC_OUT == (REG_ADDR_IN != 8'h7e); endproperty
  a_inc: assert property (p_inc) else $error("address increment flag wrong");
endmodule // pslc_regs_checker
bind pslc_regs pslc_regs_checker i_chk (.*);

// *** pslc_regs_tb_top.sv ***
// self-checking bench for the pwm script load slice
// assumes design, host model and checker are compiled before this file
`timescale 1ns/1ps
`include "pslc_map.vh"
module pslc_regs_tb_top;
  reg clk = 1'b0;
  reg rst = 1'b1;
  reg [2:0] cyc_ev = 3'h0;
  reg [2:0] scr_ev = 3'h0;
  reg [6:0] sra = 7'h00;
  reg [2:0] cmask = 3'h5;
  reg [2:0] smask = 3'h3;
  reg [7:0] v;
  wire [7:0] a, d, q;
  wire w, r, st, sp, inc;
  wire [5:0] raw, msk;
  wire [15:0] sdat;
  wire [6:0] sla;
  integer mismatches = 0;
  integer n_tests = 0;
  integer i;
  always #2 clk = ~clk;
  pslc_host_model i_host (.clk_in(clk), .rd_data_in(q), .addr_out(a), .wdata_out(d),
    .wr_out(w), .rd_out(r), .start_out(st), .stop_out(sp));
  pslc_regs i_dut (.CLOCK_IN(clk), .RST_IN(rst), .REG_ADDR_IN(a), .WR_DATA_IN(d),
    .WR_STROBE_IN(w), .RD_STROBE_IN(r), .XFER_START_IN(st), .BUS_STOP_IN(sp),
    .RD_DATA_OUT(q), .NEXT_ADDR_INC_OUT(inc), .CYCLE_DONE_IN(cyc_ev), .SCRIPT_DONE_IN(scr_ev),
    .CYCLE_MASK_IN(cmask), .SCRIPT_MASK_IN(smask), .RAW_IRQ_STATUS_OUT(raw),
    .MASKED_IRQ_STATUS_OUT(msk), .SCRIPT_RD_ADDR_IN(sra), .SCRIPT_RD_DATA_OUT(sdat),
    .SLAVE_ADDR_OUT(sla));
  task chk(input [15:0] got, input [15:0] exp);
    n_tests = n_tests + 1;
    if (got !== exp) begin
      mismatches = mismatches + 1;
      $display("ERROR t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task test_done;
    if (mismatches == 0 && n_tests > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // slot read has one cycle of latency, so wait two edges
  task slot(input [6:0] s, input [15:0] e);
    sra <= s;
    repeat (2) @(posedge clk);
    chk(sdat, e);
  endtask
  // new slave address must wait for the stop
  task t_id;
    chk(sla, `PSLC_SLAVE_RESET);
    i_host.cyc(`PSLC_ADDR_SLAVE_MAKER, 8'h5c, 1'b1);
    chk(sla, `PSLC_SLAVE_RESET);
    i_host.rd(`PSLC_ADDR_SLAVE_MAKER, v);
    chk(v, `PSLC_MAKER_CODE);
    i_host.ev(1'b1);
    chk(sla, 16'h2e);
  endtask
  // words across the timer seam, a lone byte, then the invalid range
  task t_script;
    i_host.rd(`PSLC_ADDR_WR_PTR, v);
    chk(v, 16'h00);
    chk(inc, 16'h1);
    i_host.cyc(`PSLC_ADDR_WR_PTR, 8'h1f, 1'b1);
    i_host.ev(1'b0);
    i_host.word(16'hbeef);
    chk(inc, 16'h0);
    i_host.word(16'h1234);
    i_host.cyc(`PSLC_ADDR_WORD_PORT, 8'haa, 1'b1);
    i_host.ev(1'b0);
    i_host.cyc(`PSLC_ADDR_WORD_PORT, 8'hbb, 1'b1);
    i_host.ev(1'b1);
    i_host.word(16'h5678);
    i_host.rd(`PSLC_ADDR_WR_PTR, v);
    chk(v, 16'h22);
    slot(7'h1f, 16'hbeef);
    slot(7'h20, 16'h1234);
    slot(7'h21, 16'h5678);
    i_host.cyc(`PSLC_ADDR_WR_PTR, 8'h5f, 1'b1);
    i_host.word(16'h0f0f);
    i_host.word(16'hdead);
    i_host.rd(`PSLC_ADDR_WR_PTR, v);
    chk(v, 16'h60);
    slot(7'h5f, 16'h0f0f);
  endtask
  // each clear bit alone, reserved bits set too, against all six pending
  task t_irq;
    for (i = 0; i < 6; i = i + 1) begin
      {cyc_ev, scr_ev} <= 6'h3f;
      @(posedge clk);
      {cyc_ev, scr_ev} <= 6'h00;
      @(posedge clk);
      chk(raw, 16'h3f);
      chk(msk, 16'h1d);
      i_host.cyc(`PSLC_ADDR_IRQ_CLEAR, 8'hc0 | (8'h01 << i), 1'b1);
      chk(raw, 16'h3f & ~(16'h1 << i));
      chk(msk, 16'h1d & ~(16'h1 << i));
    end
    i_host.rd(`PSLC_ADDR_IRQ_CLEAR, v);
    chk(v, 16'h00);
    // other mask pattern: script t2 and cycle t1 only
    cmask <= 3'h2;
    smask <= 3'h4;
    {cyc_ev, scr_ev} <= 6'h3f;
    @(posedge clk);
    {cyc_ev, scr_ev} <= 6'h00;
    @(posedge clk);
    chk(msk, 16'h22);
  endtask
  // reset in mid-run brings every register but the slot store back to its reset value
  task t_reset;
    rst <= 1'b1;
    @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    chk(raw, 16'h00);
    chk(sla, `PSLC_SLAVE_RESET);
    i_host.rd(`PSLC_ADDR_WR_PTR, v);
    chk(v, 16'h00);
  endtask
  initial begin
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_id;
    t_script;
    t_irq;
    t_reset;
    test_done;
  end
  // watchdog: the sequence needs under a hundred cycles
  initial begin
    #20000;
    mismatches = mismatches + 1;
    test_done;
  end
endmodule // pslc_regs_tb_top

// *** pslc_script_store.v ***
// script slot memory: three timers of 32 sixteen-bit words each
// assumes the caller only writes with a valid pointer
`timescale 1ns/1ps
module pslc_script_store #(
  parameter SLOTS = 96,
  parameter AW = 7
) (
  input wire clk_in,
  input wire wr_in,
  input wire [AW-1:0] wr_addr_in,
  input wire [15:0] wr_data_in,
  input wire [AW-1:0] rd_addr_in,
  output reg [15:0] rd_data_out
);
  reg [15:0] mem [0:SLOTS-1];

  // registered read port for the pattern engines; no reset on storage
  always @(posedge clk_in) begin
    if (wr_in) begin
      mem[wr_addr_in] <= wr_data_in;
    end
    rd_data_out <= mem[rd_addr_in];
  end
endmodule // pslc_script_store
